// ---- design/uiw_unit.sv ----
/*
  Interrupt, wake and power-mode unit. Collects eight sources into a
  sticky status register, gates with mask and global enable, vectors the
  core. Assumes pattern pins and port pins are asynchronous; bus events
  and core strobes come from logic on clk.
*/
`timescale 1ns/1ns
module uiw_unit #(
  parameter int SLOW_500 = uiw_pkg::SLOW_CYC_500 // Long count, shortenable
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic [3:0]       regAddr,
  input  wire logic [7:0]       regWdata,
  input  wire logic             regWr,
  input  wire logic             regRd,
  output logic      [7:0]       regRdata,
  input  wire logic             timerOvf,
  input  wire logic [7:0]       portPins,
  input  wire logic             chOnePin,
  input  wire logic             chTwoPin,
  input  wire logic             sampleTick,
  input  wire uiw_pkg::uiw_usb_s usbEv,
  input  wire uiw_pkg::uiw_core_s coreEv,
  input  wire logic             watchdogOvf,
  output logic                  irqTake,
  output logic      [11:0]      vectorAddr,
  output logic                  coreReset,
  output logic                  oscStop,
  output logic                  slowClkSel,
  output logic                  slowTick,
  output logic                  busRespEn
);

  // Software-visible registers
  logic [7:0] status_q, status_d;   // Sticky flags
  logic [7:0] mask_q, mask_d;       // Per-source enables
  logic [7:0] special_q, special_d; // Run, dual clock, resume
  logic [7:0] opmode_q, opmode_d;   // Pattern enable, slow freq field
  logic [7:0] ch1Lo_q, ch1Lo_d, ch1Hi_q, ch1Hi_d;
  logic [7:0] ch2Lo_q, ch2Lo_d, ch2Hi_q, ch2Hi_d;
  logic       gie_q, gie_d;         // Global enable
  logic       busArmed_q, busArmed_d;
  logic       suspPrev_q, suspPrev_d;
  logic [7:0] rdata_q, rdata_d;
  // Synchronisers: first stage read only by second
  logic [9:0] sync1_q, sync2_q;
  logic [9:0] last_q, last_d;       // Previous synchronised levels
  logic [7:0] cnt1_q, cnt1_d, cnt2_q, cnt2_d;
  logic [20:0] slowCnt_q, slowCnt_d;
  logic       tick_q, tick_d;

  // Threshold/saturation check for one channel
  function automatic logic patHit(input logic now, input logic was,
                                  input logic [7:0] cnt, input logic [7:0] lo,
                                  input logic [7:0] hi, input logic samp);
    logic fell;
    logic rose;
    fell = was & ~now;
    rose = ~was & now;
    patHit = (fell && cnt > hi) || (rose && cnt > lo) ||
             (samp && now == was && cnt == uiw_pkg::PATTERN_SAT);
  endfunction

  // Slow clock period for selection code
  function automatic logic [20:0] slowPeriod(input logic [1:0] sel);
    unique case (sel)
      2'b00: slowPeriod = 21'(SLOW_500);
      2'b01: slowPeriod = 21'(uiw_pkg::SLOW_CYC_4K);
      2'b10: slowPeriod = 21'(uiw_pkg::SLOW_CYC_32K);
      2'b11: slowPeriod = 21'(uiw_pkg::SLOW_CYC_256K);
    endcase
  endfunction

  logic [7:0] events;
  logic       patOn, slowMode, wake, pend;
  logic       ch1Now, ch2Now, ch1Was, ch2Was;

  // Two-flop synchronisers for pins
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sync1_q <= 10'h000;
      sync2_q <= 10'h000;
    end else begin
      sync1_q <= {chTwoPin, chOnePin, portPins};
      sync2_q <= sync1_q;
    end
  end

  // Event collection and register next state
  always_comb begin
    patOn   = opmode_q[uiw_pkg::BIT_PATTERN];
    slowMode = ~special_q[uiw_pkg::BIT_DUALCLK];
    ch1Now = sync2_q[8];
    ch2Now = sync2_q[9];
    ch1Was = last_q[8];
    ch2Was = last_q[9];
    events = 8'h00;
    events[uiw_pkg::BIT_TIMER]   = timerOvf;
    events[uiw_pkg::BIT_PORT]    = |(sync2_q[7:0] ^ last_q[7:0]);
    events[uiw_pkg::BIT_CH1]     = patOn &
      patHit(ch1Now, ch1Was, cnt1_q, ch1Lo_q, ch1Hi_q, sampleTick);
    events[uiw_pkg::BIT_CH2]     = patOn &
      patHit(ch2Now, ch2Was, cnt2_q, ch2Lo_q, ch2Hi_q, sampleTick);
    // Setup flags the core only for unsupported commands
    events[uiw_pkg::BIT_SETUP]   = usbEv.setupOk & usbEv.unsupported;
    events[uiw_pkg::BIT_SUSPEND] = usbEv.suspend & ~suspPrev_q;
    events[uiw_pkg::BIT_BUSRST]  = usbEv.busReset;
    // Suspend exit not caused by own resume signalling
    events[uiw_pkg::BIT_RESUME]  = suspPrev_q & ~usbEv.suspend &
                                   ~special_q[uiw_pkg::BIT_DEVRES];

    last_d     = sync2_q;
    suspPrev_d = usbEv.suspend;
    // Pattern counters: count while level holds, restart on change
    cnt1_d = cnt1_q;
    cnt2_d = cnt2_q;
    if (!patOn || ch1Now != ch1Was) begin
      cnt1_d = 8'h00;
    end else if (sampleTick) begin
      cnt1_d = cnt1_q + 8'h01; // Wraps from saturation to zero
    end
    if (!patOn || ch2Now != ch2Was) begin
      cnt2_d = 8'h00;
    end else if (sampleTick) begin
      cnt2_d = cnt2_q + 8'h01;
    end

    // Register writes; hardware set wins over software clear
    status_d  = status_q;
    mask_d    = mask_q;
    special_d = special_q;
    opmode_d  = opmode_q;
    ch1Lo_d   = ch1Lo_q;
    ch1Hi_d   = ch1Hi_q;
    ch2Lo_d   = ch2Lo_q;
    ch2Hi_d   = ch2Hi_q;
    if (regWr) begin
      unique case (regAddr)
        uiw_pkg::ADDR_STATUS:  status_d  = regWdata;
        uiw_pkg::ADDR_MASK:    mask_d    = regWdata;
        uiw_pkg::ADDR_SPECIAL: special_d = regWdata;
        uiw_pkg::ADDR_OPMODE:  opmode_d  = regWdata;
        uiw_pkg::ADDR_CH1LO:   ch1Lo_d   = regWdata;
        uiw_pkg::ADDR_CH1HI:   ch1Hi_d   = regWdata;
        uiw_pkg::ADDR_CH2LO:   ch2Lo_d   = regWdata;
        uiw_pkg::ADDR_CH2HI:   ch2Hi_d   = regWdata;
        default: ;
      endcase
    end
    status_d = status_d | events;

    // Device resume bit drops once suspend goes low
    if (!usbEv.suspend) begin
      special_d[uiw_pkg::BIT_DEVRES] = 1'b0;
    end
    // Wake from sleep: host resume, watchdog, port change
    wake = events[uiw_pkg::BIT_RESUME] | watchdogOvf | events[uiw_pkg::BIT_PORT];
    if (wake) begin
      special_d[uiw_pkg::BIT_RUN] = 1'b1;
    end

    // Global enable; watchdog restart clears it as core restarts
    gie_d = gie_q;
    if (coreEv.disable_interrupt_instruction || watchdogOvf) begin
      gie_d = 1'b0;
    end else if (coreEv.enable_interrupt_instruction || coreEv.return_from_interrupt_instruction) begin
      gie_d = 1'b1;
    end
    // Watchdog restarts the core; bus arming survives
    if (watchdogOvf) begin
      status_d = events;
      mask_d   = uiw_pkg::RST_MASK;
    end
    busArmed_d = busArmed_q | usbEv.busReset;

    // Read mux
    rdata_d = rdata_q;
    if (regRd) begin
      unique case (regAddr)
        uiw_pkg::ADDR_STATUS:  rdata_d = status_q;
        uiw_pkg::ADDR_MASK:    rdata_d = mask_q;
        uiw_pkg::ADDR_SPECIAL: rdata_d = special_q;
        uiw_pkg::ADDR_OPMODE:  rdata_d = opmode_q;
        uiw_pkg::ADDR_CH1LO:   rdata_d = ch1Lo_q;
        uiw_pkg::ADDR_CH1HI:   rdata_d = ch1Hi_q;
        uiw_pkg::ADDR_CH2LO:   rdata_d = ch2Lo_q;
        uiw_pkg::ADDR_CH2HI:   rdata_d = ch2Hi_q;
        uiw_pkg::ADDR_STATE:   rdata_d = {5'h00, busArmed_q, slowMode, gie_q};
        default:               rdata_d = 8'h00; // Unmapped reads zero
      endcase
    end

    // Slow oscillator model as a tick divider
    slowCnt_d = slowCnt_q + 21'h00_0001;
    tick_d = 1'b0;
    if (!slowMode) begin
      slowCnt_d = 21'h00_0000;
    end else if (slowCnt_q >= slowPeriod(opmode_q[uiw_pkg::BIT_FRQLO +: 2]) - 21'h00_0001) begin
      slowCnt_d = 21'h00_0000;
      tick_d = 1'b1;
    end
  end

  // Register all state but the synchronisers; power-on reset loads defaults
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      status_q   <= uiw_pkg::RST_STATUS;
      mask_q     <= uiw_pkg::RST_MASK;
      special_q  <= uiw_pkg::RST_SPECIAL;
      opmode_q   <= uiw_pkg::RST_OPMODE;
      ch1Lo_q    <= 8'h00;
      ch1Hi_q    <= 8'h00;
      ch2Lo_q    <= 8'h00;
      ch2Hi_q    <= 8'h00;
      gie_q      <= 1'b0;
      busArmed_q <= 1'b0;
      suspPrev_q <= 1'b0;
      rdata_q    <= 8'h00;
      last_q     <= 10'h000;
      cnt1_q     <= 8'h00;
      cnt2_q     <= 8'h00;
      slowCnt_q  <= 21'h00_0000;
      tick_q     <= 1'b0;
    end else begin
      status_q   <= status_d;
      mask_q     <= mask_d;
      special_q  <= special_d;
      opmode_q   <= opmode_d;
      ch1Lo_q    <= ch1Lo_d;
      ch1Hi_q    <= ch1Hi_d;
      ch2Lo_q    <= ch2Lo_d;
      ch2Hi_q    <= ch2Hi_d;
      gie_q      <= gie_d;
      busArmed_q <= busArmed_d;
      suspPrev_q <= suspPrev_d;
      rdata_q    <= rdata_d;
      last_q     <= last_d;
      cnt1_q     <= cnt1_d;
      cnt2_q     <= cnt2_d;
      slowCnt_q  <= slowCnt_d;
      tick_q     <= tick_d;
    end
  end

  // Take decision; host resume only counts in slow mode
  always_comb begin
    logic [7:0] live;
    live = status_q & mask_q;
    live[uiw_pkg::BIT_RESUME] = live[uiw_pkg::BIT_RESUME] & slowMode;
    pend = |live;
  end

  assign irqTake    = coreEv.boundary & gie_q & pend;
  assign vectorAddr = uiw_pkg::VECTOR_ADDR;
  assign coreReset  = watchdogOvf;
  assign oscStop    = ~special_q[uiw_pkg::BIT_RUN];
  assign slowClkSel = slowMode;
  assign slowTick   = tick_q;
  assign busRespEn  = busArmed_q;
  assign regRdata   = rdata_q;

  // Checks
  chk_status_sticky: assert property (@(posedge clk) disable iff (reset)
    timerOvf && !watchdogOvf |=> status_q[0]) else $error("timer flag not set");
  chk_bus_reset_flag: assert property (@(posedge clk) disable iff (reset)
    usbEv.busReset && !watchdogOvf |=> status_q[3] && busRespEn) else $error("bus reset lost");
  chk_no_take_gie: assert property (@(posedge clk) disable iff (reset)
    !gie_q |-> !irqTake) else $error("take without enable");
  chk_disable_interrupt_instruction_clears: assert property (@(posedge clk) disable iff (reset)
    coreEv.disable_interrupt_instruction |=> !gie_q) else $error("disable ignored");
  chk_masked_silent: assert property (@(posedge clk) disable iff (reset)
    mask_q == 8'h00 |-> !irqTake) else $error("masked source taken");
  chk_bus_quiet: assert property (@(posedge clk) disable iff (reset)
    !busArmed_q && !$past(usbEv.busReset) |-> !busRespEn) else $error("early response");
  chk_wake_run: assert property (@(posedge clk) disable iff (reset)
    watchdogOvf |=> !oscStop) else $error("no wake");
  chk_resume_gate: assert property (@(posedge clk) disable iff (reset)
    !slowMode && (status_q & mask_q) == 8'h80 |-> !irqTake) else $error("resume in fast mode");
  chk_port_flag: assert property (@(posedge clk) disable iff (reset)
    (sync2_q[7:0] != last_q[7:0]) && !watchdogOvf |=> status_q[4]) else $error("port flag");
endmodule

// ---- design/uiw_pkg.sv ----
/*
  Package for the interrupt and wake unit: register offsets, field
  positions, reset values, timing constants and shared carrier types.
  Assumes one 125 MHz system clock and a plain register port.
*/
// Behaviour
// - Every taken interrupt vectors to one address
// - Timer overflow sets status bit 0
// - Port level change sets status bit 4
// - Channel one edge beyond threshold sets bit 5
// - Channel one counter saturation sets bit 5
// - Channel two edge beyond threshold sets bit 6
// - Channel two counter saturation sets bit 6
// - Accepted unsupported control setup sets status bit 1
// - Bus suspend sets status bit 2
// - Bus reset sets status bit 3
// - Suspend exit without own resume sets bit 7
// - Host resume interrupt only in slow mode
// - Masked sources still set their flags
// - Global enable set by enable/return, cleared by disable
// - No bus response until first bus reset
// - Clearing run bit stops oscillator, sleeps core
// - Wake on host resume, watchdog, port change
// - Clearing dual-clock bit selects slow oscillator
// - Watchdog resets core, not the bus controller
// - Power-on reset clears counters, loads defaults
// - Only unsupported commands flag the core
// - Mask bits ordered as the status bits
// - Slow clock field picks 500 Hz to 256 kHz
package uiw_pkg;

  // Register indices on the plain register port
  localparam logic [3:0] ADDR_STATUS  = 4'h0;
  localparam logic [3:0] ADDR_MASK    = 4'h1;
  localparam logic [3:0] ADDR_SPECIAL = 4'h2;
  localparam logic [3:0] ADDR_OPMODE  = 4'h3;
  localparam logic [3:0] ADDR_CH1LO   = 4'h4;
  localparam logic [3:0] ADDR_CH1HI   = 4'h5;
  localparam logic [3:0] ADDR_CH2LO   = 4'h6;
  localparam logic [3:0] ADDR_CH2HI   = 4'h7;
  localparam logic [3:0] ADDR_STATE   = 4'h8;

  // Status and mask bit positions
  localparam int BIT_TIMER   = 0;
  localparam int BIT_SETUP   = 1;
  localparam int BIT_SUSPEND = 2;
  localparam int BIT_BUSRST  = 3;
  localparam int BIT_PORT    = 4;
  localparam int BIT_CH1     = 5;
  localparam int BIT_CH2     = 6;
  localparam int BIT_RESUME  = 7;

  // Special function control fields
  localparam int BIT_RUN     = 4;
  localparam int BIT_DUALCLK = 7;
  localparam int BIT_DEVRES  = 3;
  // Operation mode control fields
  localparam int BIT_PATTERN = 2;
  localparam int BIT_FRQLO   = 6;

  // Reset values
  localparam logic [7:0] RST_STATUS  = 8'h00;
  localparam logic [7:0] RST_MASK    = 8'h00;
  localparam logic [7:0] RST_SPECIAL = 8'hD7;
  localparam logic [7:0] RST_OPMODE  = 8'hE0;

  // Single shared vector address
  localparam logic [11:0] VECTOR_ADDR = 12'h001;
  // Pattern counter saturation value
  localparam logic [7:0] PATTERN_SAT = 8'hFF;

  // Slow clock periods in ns for codes 00..11, and cycle counts
  localparam int CLK_NS = 8;
  localparam int SLOW_NS_500   = 2000000;
  localparam int SLOW_NS_4K    = 250000;
  localparam int SLOW_NS_32K   = 31250;
  localparam int SLOW_NS_256K  = 3906;
  localparam int SLOW_CYC_500  = SLOW_NS_500 / CLK_NS;
  localparam int SLOW_CYC_4K   = SLOW_NS_4K / CLK_NS;
  localparam int SLOW_CYC_32K  = SLOW_NS_32K / CLK_NS;
  localparam int SLOW_CYC_256K = SLOW_NS_256K / CLK_NS;

  // Core power states
  typedef enum logic [1:0] {PWR_RUN, PWR_SLOW, PWR_SLEEP} uiw_pwr_e;

  // Bus controller events toward this block
  typedef struct packed {
    logic setupOk;     // Setup accepted on control endpoint
    logic unsupported; // Standard command not handled in hardware
    logic suspend;     // Bus suspend level
    logic busReset;    // Bus reset pulse
  } uiw_usb_s;

  // Instruction strobes from the core
  typedef struct packed {
    logic enable_interrupt_instruction;      // Enable-interrupt instruction
    logic return_from_interrupt_instruction;     // Return-from-interrupt instruction
    logic disable_interrupt_instruction;     // Disable-interrupt instruction
    logic boundary; // Instruction boundary
  } uiw_core_s;

endpackage

// ---- verification/uiw_far_model.sv ----
/*
  Far-side model: USB bus events toward the unit and the core's
  instruction strobes. Assumes the bench calls one task at a time.
*/
`timescale 1ns/1ns
module uiw_far_model (
  input  wire logic          clk,
  input  wire logic          irqTake,
  output uiw_pkg::uiw_usb_s  usbEv,
  output uiw_pkg::uiw_core_s coreEv
);
  // Quiet until commanded
  initial begin
    usbEv  = '0;
    coreEv = '0;
  end

  // One-cycle bus pulse; the suspend level is left alone
  task automatic usb_pulse(input logic setup, input logic unsup, input logic busRst);
    @(posedge clk);
    usbEv.setupOk     <= setup;
    usbEv.unsupported <= unsup;
    usbEv.busReset    <= busRst;
    @(posedge clk);
    usbEv.setupOk     <= 1'b0;
    usbEv.unsupported <= 1'b0;
    usbEv.busReset    <= 1'b0;
  endtask

  // Suspend is a level held by the bus
  task automatic suspend(input logic lvl);
    @(posedge clk);
    usbEv.suspend <= lvl;
  endtask

  // One instruction strobe: eni 8, return_from_interrupt_instruction 4, disable_interrupt_instruction 2
  task automatic core(input logic [3:0] ev);
    @(posedge clk);
    coreEv <= ev;
    @(posedge clk);
    coreEv <= '0;
  endtask

  // Instruction boundary; irqTake is combinational, so look mid-cycle
  task automatic boundary(output logic took);
    @(posedge clk);
    coreEv.boundary <= 1'b1;
    #1 took = irqTake;
    @(posedge clk);
    coreEv.boundary <= 1'b0;
  endtask
endmodule

// ---- verification/tb.sv ----
/*
  Self-checking bench for the interrupt and wake unit, one task per
  scenario. Assumes the far-side model for bus events and core strobes.
*/
`timescale 1ns/1ns
module tb;
  logic               clk = 1'b0;     // 125 MHz
  logic               reset = 1'b1;   // Async, active high
  logic [3:0]         regAddr;        // Driven by the bus tasks
  logic [7:0]         regWdata;
  logic               regWr;
  logic               regRd;
  logic [7:0]         regRdata;
  logic               timerOvf;
  logic [7:0]         portPins;
  logic               chOnePin;
  logic               chTwoPin;
  logic               sampleTick;
  logic               watchdogOvf;
  logic [11:0]        vectorAddr;
  logic               irqTake, coreReset, oscStop, slowClkSel, slowTick, busRespEn, took;
  uiw_pkg::uiw_usb_s  usbEv;
  uiw_pkg::uiw_core_s coreEv;
  int                 n_errors = 0;
  int                 comparisons = 0;

  always #4 clk = ~clk;

  // Slow 500 Hz count shortened to 8 cycles
  uiw_unit #(.SLOW_500(8)) i_dut (.clk(clk), .reset(reset), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .timerOvf(timerOvf), .portPins(portPins), .chOnePin(chOnePin), .chTwoPin(chTwoPin),
    .sampleTick(sampleTick), .usbEv(usbEv), .coreEv(coreEv), .watchdogOvf(watchdogOvf),
    .irqTake(irqTake), .vectorAddr(vectorAddr), .coreReset(coreReset), .oscStop(oscStop),
    .slowClkSel(slowClkSel), .slowTick(slowTick), .busRespEn(busRespEn));
  uiw_far_model i_host (.clk(clk), .irqTake(irqTake), .usbEv(usbEv), .coreEv(coreEv));

  task automatic end_sim();
    $display("comparisons %0d, mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [11:0] got, input logic [11:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    regWr    <= 1'b1;
    regAddr  <= a;
    regWdata <= d;
    @(posedge clk);
    regWr    <= 1'b0;
  endtask

  // Data stand from the cycle after the strobe until the next read
  task automatic rdchk(input logic [3:0] a, input logic [7:0] exp, input string what);
    @(posedge clk);
    regRd   <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd   <= 1'b0;
    #1 chk({4'h0, regRdata}, {4'h0, exp}, what);
  endtask

  task automatic bchk(input logic exp, input string what);
    i_host.boundary(took);
    chk({11'h000, took}, {11'h000, exp}, what);
  endtask

  task automatic t_reset();
    rdchk(uiw_pkg::ADDR_STATUS, 8'h00, "status reset");
    rdchk(uiw_pkg::ADDR_MASK, 8'h00, "mask reset");
    rdchk(uiw_pkg::ADDR_SPECIAL, 8'hD7, "special reset");
    rdchk(uiw_pkg::ADDR_OPMODE, 8'hE0, "opmode reset");
    rdchk(4'hF, 8'h00, "unmapped read");
    chk({11'h000, busRespEn}, 12'h000, "bus silent before reset");
  endtask

  // Timer flag, masking, global enable, vector
  task automatic t_timer();
    @(posedge clk);
    timerOvf <= 1'b1;
    @(posedge clk);
    timerOvf <= 1'b0;
    rdchk(uiw_pkg::ADDR_STATUS, 8'h01, "timer flag");
    i_host.core(4'h8);
    bchk(1'b0, "masked source vectored");
    wr(uiw_pkg::ADDR_MASK, 8'h01);
    bchk(1'b1, "enabled source not taken");
    chk(vectorAddr, uiw_pkg::VECTOR_ADDR, "vector");
    i_host.core(4'h2);
    bchk(1'b0, "taken after disable");
    i_host.core(4'h4);
    bchk(1'b1, "not taken after return");
    rdchk(uiw_pkg::ADDR_STATUS, 8'h01, "flag self-cleared");
    wr(uiw_pkg::ADDR_STATUS, 8'h00); // Firmware clears
    rdchk(uiw_pkg::ADDR_STATUS, 8'h00, "flag clear");
    i_host.core(4'h2);
  endtask

  // Setup, suspend, bus reset, host resume in both clock modes
  task automatic t_usb();
    i_host.usb_pulse(1'b1, 1'b0, 1'b0);
    rdchk(uiw_pkg::ADDR_STATUS, 8'h00, "supported command flagged");
    i_host.usb_pulse(1'b1, 1'b1, 1'b0);
    rdchk(uiw_pkg::ADDR_STATUS, 8'h02, "setup flag");
    i_host.suspend(1'b1);
    rdchk(uiw_pkg::ADDR_STATUS, 8'h06, "suspend flag");
    i_host.usb_pulse(1'b0, 1'b0, 1'b1);
    rdchk(uiw_pkg::ADDR_STATUS, 8'h0E, "bus reset flag");
    chk({11'h000, busRespEn}, 12'h001, "bus silent after reset");
    wr(uiw_pkg::ADDR_STATUS, 8'h00);
    wr(uiw_pkg::ADDR_MASK, 8'h80);
    i_host.core(4'h8);
    i_host.suspend(1'b0);
    rdchk(uiw_pkg::ADDR_STATUS, 8'h80, "resume flag");
    bchk(1'b0, "resume taken in fast mode");
    wr(uiw_pkg::ADDR_SPECIAL, 8'h57);
    bchk(1'b1, "resume not taken in slow mode");
    wr(uiw_pkg::ADDR_SPECIAL, 8'hD7);
    i_host.core(4'h2);
    wr(uiw_pkg::ADDR_STATUS, 8'h00);
  endtask

  // Sleep, then wake on a port change
  task automatic t_port();
    wr(uiw_pkg::ADDR_SPECIAL, 8'h87);
    #1 chk({11'h000, oscStop}, 12'h001, "no sleep");
    @(posedge clk);
    portPins <= 8'h01;
    for (int c = 0; c < 12 && oscStop !== 1'b0; c++) @(posedge clk);
    #1 chk({11'h000, oscStop}, 12'h000, "no wake");
    rdchk(uiw_pkg::ADDR_STATUS, 8'h10, "port flag");
    wr(uiw_pkg::ADDR_STATUS, 8'h00);
    wr(uiw_pkg::ADDR_SPECIAL, 8'hD7);
  endtask

  // Gap between the second and third slow tick after a code change
  task automatic tickgap(input logic [1:0] code, input int exp);
    int c;
    wr(uiw_pkg::ADDR_OPMODE, {code, 6'h20});
    for (int k = 0; k < 3; k++) begin
      c = 0;
      do begin
        @(posedge clk);
        #1 c++;
      end while (slowTick !== 1'b1 && c < 2 * exp + 20);
      if (c >= 2 * exp + 20) begin
        n_errors++;
        end_sim();
      end
    end
    chk(12'(c), 12'(exp), "slow period");
  endtask

  task automatic t_slow();
    wr(uiw_pkg::ADDR_SPECIAL, 8'h57);
    #1 chk({11'h000, slowClkSel}, 12'h001, "slow clock off");
    tickgap(2'b00, 8);
    tickgap(2'b10, uiw_pkg::SLOW_CYC_32K);
    tickgap(2'b11, uiw_pkg::SLOW_CYC_256K);
    wr(uiw_pkg::ADDR_SPECIAL, 8'hD7);
    wr(uiw_pkg::ADDR_OPMODE, 8'hE0);
  endtask

  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge clk);
      sampleTick <= 1'b1;
      @(posedge clk);
      sampleTick <= 1'b0;
    end
  endtask

  // Saturation on both channels, then a long low pattern ending
  task automatic t_pattern();
    wr(uiw_pkg::ADDR_OPMODE, 8'hE4);
    ticks(300);
    rdchk(uiw_pkg::ADDR_STATUS, 8'h60, "saturation flags");
    wr(uiw_pkg::ADDR_CH1LO, 8'h02);
    wr(uiw_pkg::ADDR_STATUS, 8'h00);
    ticks(6);
    @(posedge clk);
    chOnePin <= 1'b1;
    ticks(10);
    rdchk(uiw_pkg::ADDR_STATUS, 8'h20, "channel one edge flag");
    // Channel two rises after a long low run, beyond its zero threshold
    @(posedge clk);
    chTwoPin <= 1'b1;
    ticks(4);
    rdchk(uiw_pkg::ADDR_STATUS, 8'h60, "channel two edge flag");
  endtask

  // Core restarts, bus controller keeps its state
  task automatic t_watchdog();
    @(posedge clk);
    watchdogOvf <= 1'b1;
    #1 chk({11'h000, coreReset}, 12'h001, "no core reset");
    @(posedge clk);
    watchdogOvf <= 1'b0;
    #1 chk({11'h000, busRespEn}, 12'h001, "bus state lost");
  endtask

  initial begin
    // Every input quiet while reset is held
    regAddr     = 4'h0;
    regWdata    = 8'h00;
    regWr       = 1'b0;
    regRd       = 1'b0;
    timerOvf    = 1'b0;
    portPins    = 8'h00;
    chOnePin    = 1'b0;
    chTwoPin    = 1'b0;
    sampleTick  = 1'b0;
    watchdogOvf = 1'b0;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    t_reset();
    t_timer();
    t_usb();
    t_port();
    t_slow();
    t_pattern();
    t_watchdog();
    end_sim();
  end
endmodule
